// File: ipg_pkg.sv
// Constants for the transmit interpacket gap control block.
// Assumes a single 50 MHz clock and the plain register port of the block.
package ipg_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int unsigned GAP_W  = 7;
  localparam int unsigned CNT_W  = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_GAP        = 8'h00;
  localparam logic [7:0] OFF_GAP_DROP   = 8'h04;
  localparam logic [7:0] OFF_GAP_RAISE  = 8'h08;
  localparam logic [7:0] OFF_GAP_TOGGLE = 8'h0C;
  localparam logic [7:0] OFF_MODE       = 8'h10;
  localparam logic [7:0] OFF_STATUS     = 8'h14;

  // ----------------------------------------------------------------------
  // Reset values and offsets
  // ----------------------------------------------------------------------
  localparam logic [6:0] GAP_RESET   = 7'h12;
  localparam logic       MODE_RESET  = 1'b0;
  localparam logic [7:0] FULL_OFFSET = 8'h03;
  localparam logic [7:0] HALF_OFFSET = 8'h06;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned MODE_FULL_BIT     = 0;
  localparam int unsigned STATUS_DONE_BIT   = 0;
  localparam int unsigned STATUS_TARGET_LSB = 8;
  localparam int unsigned STATUS_COUNT_LSB  = 16;

  // ----------------------------------------------------------------------
  // Access size codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] SIZE_8  = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;

  typedef enum logic [1:0] {
    IPG_WR_PLAIN,
    IPG_WR_DROP,
    IPG_WR_RAISE,
    IPG_WR_TOGGLE
  } ipg_wr_kind_e;

endpackage : ipg_pkg

// File: ipg_gap_counter.sv
// Nibble-time gap counter between back-to-back transmitted packets.
// Assumes nibble_tick is a one-cycle pulse once per nibble time.
`timescale 1ns/1ps
module ipg_gap_counter #(
  parameter int unsigned CNT_W = ipg_pkg::CNT_W
) (
  input  logic             clk,
  input  logic             reset,
  input  logic             frame_end,
  input  logic             nibble_tick,
  input  logic [CNT_W-1:0] target,
  output logic             gap_ok,
  output logic [CNT_W-1:0] elapsed
);

  logic             busy_q;
  logic             busy_d;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  always_comb
  begin
    busy_d  = busy_q;
    count_d = count_q;
    if (frame_end)
    begin
      busy_d  = 1'b1;
      count_d = '0;
    end
    else if (busy_q && (count_q >= target))
    begin
      busy_d = 1'b0;
    end
    else if (busy_q && nibble_tick)
    begin
      count_d = count_q + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      busy_q  <= 1'b0;
      count_q <= '0;
    end
    else
    begin
      busy_q  <= busy_d;
      count_q <= count_d;
    end
  end

  // Target may move mid-gap; the live value is compared
  assign gap_ok  = !busy_q;
  assign elapsed = count_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_gap_blocks_start : assert property (
    @(posedge clk) disable iff (reset)
    frame_end |=> !gap_ok)
    else $error("gap not held after frame end");

  a_gap_release_count : assert property (
    @(posedge clk) disable iff (reset)
    $rose(gap_ok) |-> $past(count_q) >= $past(target))
    else $error("gap released before target reached");

endmodule : ipg_gap_counter

// File: ipg_gap_ctrl.sv
// Transmit back-to-back gap control: register file plus gap counter.
// Assumes one clock, synchronous strobes and a tick per nibble time.
//
// Functional notes
// - Hold 7-bit minimum gap field in nibbles
// - Full duplex enforces field plus three
// - Half duplex enforces field plus six
// - 16/32-bit accesses work, 8-bit ignored
// - Bits 31 to 7 read zero
// - Drop, raise, toggle aliases at 4/8/C
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module ipg_gap_ctrl #(
  parameter int unsigned GAP_W = ipg_pkg::GAP_W,
  parameter int unsigned CNT_W = ipg_pkg::CNT_W
) (
  input  logic                        clk,
  input  logic                        reset,
  input  logic [ipg_pkg::ADDR_W-1:0]  reg_addr,
  input  logic [ipg_pkg::DATA_W-1:0]  reg_wdata,
  input  logic [1:0]                  reg_size,
  input  logic                        reg_wr,
  input  logic                        reg_rd,
  output logic [ipg_pkg::DATA_W-1:0]  reg_rdata,
  input  logic                        tx_frame_end,
  input  logic                        nibble_tick,
  output logic                        tx_gap_ok,
  output logic                        full_duplex
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (GAP_W < 1 || GAP_W > 7)
  begin : g_bad_gap_w
    $error("GAP_W must be 1 to 7");
  end
  // Counter must hold field plus six; status packs it into eight bits
  if ((1 << CNT_W) < (1 << GAP_W) + 6 || CNT_W > 8)
  begin : g_bad_cnt_w
    $error("CNT_W must hold the largest target and stay within 8");
  end

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Lanes a write may touch; 8-bit and unknown sizes touch none
  function automatic logic [31:0] lane_mask(input logic [1:0] size,
                                           input logic       upper);
    logic [31:0] m;
    m = 32'h0000_0000;
    if (size == ipg_pkg::SIZE_32)
    begin
      m = 32'hFFFF_FFFF;
    end
    else if (size == ipg_pkg::SIZE_16)
    begin
      m = upper ? 32'hFFFF_0000 : 32'h0000_FFFF;
    end
    return m;
  endfunction : lane_mask

  // Low two address bits only pick a half; the word decides the register
  function automatic logic [ipg_pkg::ADDR_W-1:0] word_addr(
    input logic [ipg_pkg::ADDR_W-1:0] addr
  );
    return {addr[ipg_pkg::ADDR_W-1:2], 2'b00};
  endfunction : word_addr

  function automatic logic [GAP_W-1:0] apply_write(
    input logic [GAP_W-1:0]    cur,
    input logic [GAP_W-1:0]    data,
    input logic [GAP_W-1:0]    mask,
    input ipg_pkg::ipg_wr_kind_e kind
  );
    logic [GAP_W-1:0] v;
    v = cur;
    unique case (kind)
      ipg_pkg::IPG_WR_PLAIN:  v = (cur & ~mask) | (data & mask);
      ipg_pkg::IPG_WR_DROP:   v = cur & ~(data & mask);
      ipg_pkg::IPG_WR_RAISE:  v = cur | (data & mask);
      ipg_pkg::IPG_WR_TOGGLE: v = cur ^ (data & mask);
    endcase
    return v;
  endfunction : apply_write

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [GAP_W-1:0]           gap_q;
  logic [GAP_W-1:0]           gap_d;
  logic                       mode_q;
  logic                       mode_d;
  logic [31:0]                rdata_q;
  logic [31:0]                rdata_d;
  logic [31:0]                wmask;
  logic                       wr_ok;
  logic                       rd_ok;
  logic                       gap_hit;
  ipg_pkg::ipg_wr_kind_e      wr_kind;
  logic [CNT_W-1:0]           target;
  logic [CNT_W-1:0]           elapsed;

  // 8-bit accesses are dropped whole, reads as well as writes
  assign wmask = lane_mask(reg_size, reg_addr[1]);
  assign wr_ok = reg_wr && (wmask != 32'h0000_0000);
  assign rd_ok = reg_rd && (wmask != 32'h0000_0000);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    gap_hit = 1'b1;
    wr_kind = ipg_pkg::IPG_WR_PLAIN;
    unique case (word_addr(reg_addr))
      ipg_pkg::OFF_GAP:        wr_kind = ipg_pkg::IPG_WR_PLAIN;
      ipg_pkg::OFF_GAP_DROP:   wr_kind = ipg_pkg::IPG_WR_DROP;
      ipg_pkg::OFF_GAP_RAISE:  wr_kind = ipg_pkg::IPG_WR_RAISE;
      ipg_pkg::OFF_GAP_TOGGLE: wr_kind = ipg_pkg::IPG_WR_TOGGLE;
      default:                 gap_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_comb
  begin
    gap_d  = gap_q;
    mode_d = mode_q;
    if (wr_ok && gap_hit)
    begin
      // Bits above the field have no storage
      gap_d = apply_write(gap_q, reg_wdata[GAP_W-1:0], wmask[GAP_W-1:0],
                          wr_kind);
    end
    else if (wr_ok && (word_addr(reg_addr) == ipg_pkg::OFF_MODE))
    begin
      if (wmask[ipg_pkg::MODE_FULL_BIT])
      begin
        mode_d = reg_wdata[ipg_pkg::MODE_FULL_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  // Read data stand one cycle only, then fall back to zero
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (rd_ok)
    begin
      if (gap_hit)
      begin
        rdata_d[GAP_W-1:0] = gap_q;
      end
      else if (word_addr(reg_addr) == ipg_pkg::OFF_MODE)
      begin
        rdata_d[ipg_pkg::MODE_FULL_BIT] = mode_q;
      end
      else if (word_addr(reg_addr) == ipg_pkg::OFF_STATUS)
      begin
        rdata_d[ipg_pkg::STATUS_DONE_BIT] = tx_gap_ok;
        rdata_d[ipg_pkg::STATUS_TARGET_LSB +: CNT_W] = target;
        rdata_d[ipg_pkg::STATUS_COUNT_LSB +: CNT_W]  = elapsed;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      gap_q   <= ipg_pkg::GAP_RESET[GAP_W-1:0];
      mode_q  <= ipg_pkg::MODE_RESET;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      gap_q   <= gap_d;
      mode_q  <= mode_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata   = rdata_q;
  assign full_duplex = mode_q;

  // ----------------------------------------------------------------------
  // Gap target
  // ----------------------------------------------------------------------
  // Offset differs by duplex; software programs the reduced value
  assign target = CNT_W'(gap_q) + (mode_q ? CNT_W'(ipg_pkg::FULL_OFFSET)
                                          : CNT_W'(ipg_pkg::HALF_OFFSET));

  ipg_gap_counter #(
    .CNT_W (CNT_W)
  ) u_gap_counter (
    .clk         (clk),
    .reset       (reset),
    .frame_end   (tx_frame_end),
    .nibble_tick (nibble_tick),
    .target      (target),
    .gap_ok      (tx_gap_ok),
    .elapsed     (elapsed)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Aligned offset, so a 16-bit write here reaches the low half
  sequence s_full_write(logic [7:0] off);
    reg_wr && (reg_size == ipg_pkg::SIZE_16 || reg_size == ipg_pkg::SIZE_32)
    && reg_addr == off;
  endsequence

  a_gap_reset_value : assert property (
    @(posedge clk)
    $fell(reset) |-> gap_q == ipg_pkg::GAP_RESET[GAP_W-1:0])
    else $error("gap field reset value wrong");

  a_byte_write_ignored : assert property (
    @(posedge clk) disable iff (reset)
    reg_wr && reg_size == ipg_pkg::SIZE_8 |=> $stable(gap_q) && $stable(mode_q))
    else $error("8-bit write changed a register");

  a_upper_bits_zero : assert property (
    @(posedge clk) disable iff (reset)
    reg_rd && reg_size == ipg_pkg::SIZE_32 && reg_addr == ipg_pkg::OFF_GAP
    |=> reg_rdata[31:GAP_W] == '0 && reg_rdata[GAP_W-1:0] == $past(gap_q))
    else $error("gap read returned wrong bits");

  a_drop_alias : assert property (
    @(posedge clk) disable iff (reset)
    s_full_write(ipg_pkg::OFF_GAP_DROP)
    |=> gap_q == ($past(gap_q) & ~$past(reg_wdata[GAP_W-1:0])))
    else $error("drop alias wrong");

  a_raise_alias : assert property (
    @(posedge clk) disable iff (reset)
    s_full_write(ipg_pkg::OFF_GAP_RAISE)
    |=> gap_q == ($past(gap_q) | $past(reg_wdata[GAP_W-1:0])))
    else $error("raise alias wrong");

  a_toggle_alias : assert property (
    @(posedge clk) disable iff (reset)
    s_full_write(ipg_pkg::OFF_GAP_TOGGLE)
    |=> gap_q == ($past(gap_q) ^ $past(reg_wdata[GAP_W-1:0])))
    else $error("toggle alias wrong");

  a_full_offset : assert property (
    @(posedge clk) disable iff (reset)
    mode_q |-> target == CNT_W'(gap_q) + CNT_W'(3))
    else $error("full duplex target wrong");

  a_half_offset : assert property (
    @(posedge clk) disable iff (reset)
    !mode_q |-> target == CNT_W'(gap_q) + CNT_W'(6))
    else $error("half duplex target wrong");

  a_mode_reset_value : assert property (
    @(posedge clk)
    $fell(reset) |-> mode_q == ipg_pkg::MODE_RESET)
    else $error("mode reset value wrong");

  a_plain_write : assert property (
    @(posedge clk) disable iff (reset)
    s_full_write(ipg_pkg::OFF_GAP)
    |=> gap_q == $past(reg_wdata[GAP_W-1:0]))
    else $error("plain gap write wrong");

  a_mode_write : assert property (
    @(posedge clk) disable iff (reset)
    s_full_write(ipg_pkg::OFF_MODE)
    |=> mode_q == $past(reg_wdata[ipg_pkg::MODE_FULL_BIT]))
    else $error("mode write wrong");

  a_upper_half_ignored : assert property (
    @(posedge clk) disable iff (reset)
    reg_wr && reg_size == ipg_pkg::SIZE_16 && reg_addr[1]
    |=> $stable(gap_q) && $stable(mode_q))
    else $error("upper half write changed a register");

  a_byte_read_zero : assert property (
    @(posedge clk) disable iff (reset)
    reg_rd && (reg_size == ipg_pkg::SIZE_8 || reg_size == 2'h3)
    |=> reg_rdata == 32'h0000_0000)
    else $error("ignored read returned data");

  a_status_read : assert property (
    @(posedge clk) disable iff (reset)
    reg_rd && reg_size == ipg_pkg::SIZE_32 && reg_addr == ipg_pkg::OFF_STATUS
    |=> reg_rdata[ipg_pkg::STATUS_DONE_BIT] == $past(tx_gap_ok)
        && reg_rdata[ipg_pkg::STATUS_TARGET_LSB-1:1] == '0)
    else $error("status read wrong");

endmodule : ipg_gap_ctrl

// File: ipg_phy_model.sv
// Far-side transmit path model: nibble pacing and packet end pulses.
// Assumes the gap block's clock and reset; the testbench requests sends.
`timescale 1ns/1ps
module ipg_phy_model #(
  parameter int unsigned TICK_DIV = 4
) (
  input  logic clk,
  input  logic reset,
  input  logic send,
  input  logic tx_gap_ok,
  output logic nibble_tick,
  output logic tx_frame_end
);
  int unsigned div_q;

  // ----------------------------------------------------------------------
  // Nibble pacing, free running like the line clock
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      div_q        <= 0;
      nibble_tick  <= 1'b0;
      tx_frame_end <= 1'b0;
    end
    else
    begin
      div_q        <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
      nibble_tick  <= (div_q == TICK_DIV - 1);
      // Never starts a packet inside a gap, as a real transmitter
      tx_frame_end <= send && tx_gap_ok;
    end
  end
endmodule : ipg_phy_model

// File: testbench.sv
// Self-checking bench for the back-to-back gap control block.
// Assumes the register port of the block and the far-side model.
`timescale 1ns/1ps
module testbench;
  logic        clk       = 1'b0;
  logic        reset     = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [1:0]  reg_size  = 2'h2;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        send      = 1'b0;
  logic [31:0] reg_rdata;
  logic        tx_frame_end;
  logic        nibble_tick;
  logic        tx_gap_ok;
  logic        full_duplex;
  int          n_fail    = 0;
  int          checked   = 0;

  always #10 clk = ~clk;

  ipg_gap_ctrl DUT (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_size(reg_size), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_frame_end(tx_frame_end), .nibble_tick(nibble_tick),
    .tx_gap_ok(tx_gap_ok), .full_duplex(full_duplex)
  );

  ipg_phy_model #(.TICK_DIV(4)) PHY (
    .clk(clk), .reset(reset), .send(send), .tx_gap_ok(tx_gap_ok),
    .nibble_tick(nibble_tick), .tx_frame_end(tx_frame_end)
  );

  // ----------------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------------
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] s);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    reg_size  <= s;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [1:0] s, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    reg_size <= s;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk32(reg_rdata, exp);
  endtask : rd

  // Counts nibble ticks seen while the gap holds the next packet back
  task automatic gap_run(input logic full, input logic [6:0] gap, input int exp);
    int n;
    n = 0;
    wr(ipg_pkg::OFF_MODE, {31'h0000_0000, full}, ipg_pkg::SIZE_32);
    wr(ipg_pkg::OFF_GAP, {25'h000_0000, gap}, ipg_pkg::SIZE_32);
    @(posedge clk);
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
    #1;
    // Look after each edge, once the design's outputs have settled
    repeat (1000)
    begin
      if (tx_gap_ok === 1'b1)
        break;
      if (nibble_tick === 1'b1)
        n++;
      @(posedge clk);
      #1;
    end
    chk32(32'(n), 32'(exp));
    chk32({31'h0000_0000, full_duplex}, {31'h0000_0000, full});
    $display("test gap %h full %0d done", gap, full);
  endtask : gap_run

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd(ipg_pkg::OFF_GAP, ipg_pkg::SIZE_32, 32'h0000_0012);
    chk32({31'h0000_0000, tx_gap_ok}, 32'h0000_0001);
    wr(ipg_pkg::OFF_GAP, 32'hFFFF_FFFF, ipg_pkg::SIZE_32);
    rd(ipg_pkg::OFF_GAP, ipg_pkg::SIZE_32, 32'h0000_007F);
    wr(ipg_pkg::OFF_GAP, 32'h0000_0000, ipg_pkg::SIZE_8);
    rd(ipg_pkg::OFF_GAP, ipg_pkg::SIZE_32, 32'h0000_007F);
    rd(ipg_pkg::OFF_GAP, ipg_pkg::SIZE_8, 32'h0000_0000);
    wr(ipg_pkg::OFF_GAP, 32'h0000_0005, ipg_pkg::SIZE_16);
    rd(ipg_pkg::OFF_GAP, ipg_pkg::SIZE_16, 32'h0000_0005);
    wr(8'h02, 32'h007F_0000, ipg_pkg::SIZE_16);
    rd(ipg_pkg::OFF_GAP, ipg_pkg::SIZE_32, 32'h0000_0005);
    $display("test access sizes done");
    wr(ipg_pkg::OFF_GAP_RAISE, 32'h0000_0030, ipg_pkg::SIZE_32);
    rd(ipg_pkg::OFF_GAP, ipg_pkg::SIZE_32, 32'h0000_0035);
    wr(ipg_pkg::OFF_GAP_DROP, 32'h0000_0005, ipg_pkg::SIZE_16);
    rd(ipg_pkg::OFF_GAP, ipg_pkg::SIZE_32, 32'h0000_0030);
    wr(ipg_pkg::OFF_GAP_TOGGLE, 32'h0000_0041, ipg_pkg::SIZE_32);
    rd(ipg_pkg::OFF_GAP, ipg_pkg::SIZE_32, 32'h0000_0071);
    wr(ipg_pkg::OFF_GAP_TOGGLE, 32'h0000_007F, ipg_pkg::SIZE_8);
    rd(ipg_pkg::OFF_GAP, ipg_pkg::SIZE_32, 32'h0000_0071);
    wr(8'h40, 32'hFFFF_FFFF, ipg_pkg::SIZE_32);
    rd(8'h40, ipg_pkg::SIZE_32, 32'h0000_0000);
    $display("test aliases done");
    gap_run(1'b0, 7'h12, 24);
    rd(ipg_pkg::OFF_STATUS, ipg_pkg::SIZE_32, 32'h0018_1801);
    gap_run(1'b1, 7'h15, 24);
    rd(ipg_pkg::OFF_MODE, ipg_pkg::SIZE_32, 32'h0000_0001);
    gap_run(1'b1, 7'h00, 3);
    rd(ipg_pkg::OFF_STATUS, ipg_pkg::SIZE_32, 32'h0003_0301);
    gap_run(1'b0, 7'h7F, 133);
    give_verdict();
  end

  // Whole run needs about 850 cycles; this leaves ample margin
  initial
  begin
    #200000;
    n_fail++;
    give_verdict();
  end
endmodule : testbench
